// *** hw/high_port_gpio_bank.sv ***
// High-port I/O bank: port five and six latches, three drive-select registers
`timescale 1ns/100ps
module high_port_gpio_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic [7:0]               register_page_select,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic                     rmw_read,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  output logic                          sfr_hit,
  input  wire logic                     mem_active,
  input  wire high_port_pkg::mem_mode_t  mem_mode,
  input  wire logic [15:0]              mem_addr,
  input  wire logic [WIDTH-1:0]         port_five_pin_in,
  output logic      [WIDTH-1:0]         port_five_pin_out,
  output logic      [WIDTH-1:0]         port_five_pin_oe,
  input  wire logic [WIDTH-1:0]         port_six_pin_in,
  output logic      [WIDTH-1:0]         port_six_pin_out,
  output logic      [WIDTH-1:0]         port_six_pin_oe,
  output logic      [WIDTH-1:0]         port_four_drive_select
);
  import high_port_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] five_latch;
    logic [WIDTH-1:0] six_latch;
    logic [WIDTH-1:0] four_drive;
    logic [WIDTH-1:0] five_drive;
    logic [WIDTH-1:0] six_drive;
    logic [WIDTH-1:0] five_out;
    logic [WIDTH-1:0] five_oe;
    logic [WIDTH-1:0] six_out;
    logic [WIDTH-1:0] six_oe;
    logic [7:0]       rdata;
    logic             hit;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Decode used for every register: address match on page F only
  function automatic logic sel(input logic [7:0] addr, input logic [7:0] page,
                               input logic [7:0] offset);
    sel = (page == SFR_PAGE_F) && (addr == offset);
  endfunction

  logic             sel_five_data;
  logic             sel_six_data;
  logic             sel_four_drive;
  logic             sel_five_drive;
  logic             sel_six_drive;
  logic             five_take;
  logic             six_take;
  logic [WIDTH-1:0] six_mem_value;
  logic [WIDTH-1:0] five_out_next;
  logic [WIDTH-1:0] five_oe_next;
  logic [WIDTH-1:0] six_out_next;
  logic [WIDTH-1:0] six_oe_next;

  assign sel_five_data  = sel(sfr_addr, register_page_select, PORT_FIVE_DATA_ADDR);
  assign sel_six_data   = sel(sfr_addr, register_page_select, PORT_SIX_DATA_ADDR);
  assign sel_four_drive = sel(sfr_addr, register_page_select, PORT_FOUR_DRIVE_ADDR);
  assign sel_five_drive = sel(sfr_addr, register_page_select, PORT_FIVE_DRIVE_ADDR);
  assign sel_six_drive  = sel(sfr_addr, register_page_select, PORT_SIX_DRIVE_ADDR);

  // ==========================================================
  // Memory interface takeover
  assign five_take      = mem_active && (mem_mode == MEM_NONMUX);
  assign six_take       = mem_active;
  assign six_mem_value  = (mem_mode == MEM_MUX) ?
                          mem_addr[ADDR_HI_LSB +: WIDTH] :
                          mem_addr[ADDR_LO_LSB +: WIDTH];

  // Drivers see the next latch so the pins follow a write on the same edge
  port_pin_driver #(.WIDTH(WIDTH)) u_five (
    .latch        (state_next.five_latch),
    .drive_select (state_next.five_drive),
    .mem_take     (five_take),
    .mem_value    (mem_addr[ADDR_HI_LSB +: WIDTH]),
    .pin_out_next (five_out_next),
    .pin_oe_next  (five_oe_next)
  );

  port_pin_driver #(.WIDTH(WIDTH)) u_six (
    .latch        (state_next.six_latch),
    .drive_select (state_next.six_drive),
    .mem_take     (six_take),
    .mem_value    (six_mem_value),
    .pin_out_next (six_out_next),
    .pin_oe_next  (six_oe_next)
  );

  // ==========================================================
  // Next state
  always_comb begin
    state_next          = state_reg;
    state_next.hit      = 1'b0;
    state_next.rdata    = RDATA_RESET;
    if (sfr_wr) begin
      if (sel_five_data) begin
        state_next.five_latch = sfr_wdata[WIDTH-1:0];
      end else if (sel_six_data) begin
        state_next.six_latch = sfr_wdata[WIDTH-1:0];
      end else if (sel_four_drive) begin
        state_next.four_drive = sfr_wdata[WIDTH-1:0];
      end else if (sel_five_drive) begin
        state_next.five_drive = sfr_wdata[WIDTH-1:0];
      end else if (sel_six_drive) begin
        state_next.six_drive = sfr_wdata[WIDTH-1:0];
      end
    end
    if (sfr_rd) begin
      state_next.hit = sel_five_data | sel_six_data | sel_four_drive |
                       sel_five_drive | sel_six_drive;
      // Latch read on read-modify-write avoids loading a pulled-low pin back as zero
      if (sel_five_data) begin
        state_next.rdata = rmw_read ? state_reg.five_latch : port_five_pin_in;
      end else if (sel_six_data) begin
        state_next.rdata = rmw_read ? state_reg.six_latch : port_six_pin_in;
      end else if (sel_four_drive) begin
        state_next.rdata = state_reg.four_drive;
      end else if (sel_five_drive) begin
        state_next.rdata = state_reg.five_drive;
      end else if (sel_six_drive) begin
        state_next.rdata = state_reg.six_drive;
      end
    end
    state_next.five_out = five_out_next;
    state_next.five_oe  = five_oe_next;
    state_next.six_out  = six_out_next;
    state_next.six_oe   = six_oe_next;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg.five_latch <= LATCH_RESET;
      state_reg.six_latch  <= LATCH_RESET;
      state_reg.four_drive <= DRIVE_RESET;
      state_reg.five_drive <= DRIVE_RESET;
      state_reg.six_drive  <= DRIVE_RESET;
      state_reg.five_out   <= LATCH_RESET;
      state_reg.five_oe    <= DRIVE_RESET;
      state_reg.six_out    <= LATCH_RESET;
      state_reg.six_oe     <= DRIVE_RESET;
      state_reg.rdata      <= RDATA_RESET;
      state_reg.hit        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata              = state_reg.rdata;
  assign sfr_hit                = state_reg.hit;
  assign port_five_pin_out      = state_reg.five_out;
  assign port_five_pin_oe       = state_reg.five_oe;
  assign port_six_pin_out       = state_reg.six_out;
  assign port_six_pin_oe        = state_reg.six_oe;
  assign port_four_drive_select = state_reg.four_drive;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_low_drive;
    (sfr_wr && sel_five_data && !mem_active) |=>
      (((port_five_pin_out | ~port_five_pin_oe) & ~$past(sfr_wdata)) == 8'h00);
  endproperty
  a_low_drive: assert property (p_low_drive) else $error("latch zero not driven low");

  property p_open_drain;
    (sfr_wr && sel_six_data && !mem_active && state_reg.six_drive == 8'h00) |=>
      ((port_six_pin_oe & $past(sfr_wdata)) == 8'h00);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain one is driven");

  property p_push_pull;
    (sfr_wr && sel_five_data && !mem_active && state_reg.five_drive == 8'hff) |=>
      (port_five_pin_oe == 8'hff) && (port_five_pin_out == $past(sfr_wdata));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

  property p_pin_read;
    (sfr_rd && sel_five_data && !rmw_read) |=>
      (sfr_rdata == $past(port_five_pin_in)) && sfr_hit;
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("read did not return pins");

  property p_rmw_read;
    (sfr_rd && sel_six_data && rmw_read) |=> (sfr_rdata == $past(state_reg.six_latch));
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read did not return latch");

  property p_five_addr_hi;
    (mem_active && mem_mode == MEM_NONMUX) |=>
      (port_five_pin_out == $past(mem_addr[15:8]));
  endproperty
  a_five_addr_hi: assert property (p_five_addr_hi) else $error("port five not address");

  property p_six_mux;
    (mem_active && mem_mode == MEM_MUX) |=> (port_six_pin_out == $past(mem_addr[15:8]));
  endproperty
  a_six_mux: assert property (p_six_mux) else $error("port six not address high");

  property p_six_nonmux;
    (mem_active && mem_mode == MEM_NONMUX) |=>
      (port_six_pin_out == $past(mem_addr[7:0]));
  endproperty
  a_six_nonmux: assert property (p_six_nonmux) else $error("port six not address low");

  property p_page_gate;
    (sfr_wr && sfr_addr == PORT_FIVE_DATA_ADDR && register_page_select != SFR_PAGE_F) |=>
      (state_reg.five_latch == $past(state_reg.five_latch));
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("latch written off page");

  property p_reset_mode;
    @(posedge clock) disable iff (1'b0)
      reset |=> (port_four_drive_select == 8'h00) && (port_five_pin_oe == 8'h00) &&
                (port_six_pin_oe == 8'h00);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("drive select not cleared");

  property p_drive_rw;
    (sfr_wr && sel_four_drive) ##1 (sfr_rd && sel_four_drive && !sfr_wr) |=>
      (sfr_rdata == $past(sfr_wdata, 2)) && (port_four_drive_select == sfr_rdata);
  endproperty
  a_drive_rw: assert property (p_drive_rw) else $error("drive select readback wrong");

  c_rmw: cover property (sfr_rd && sel_five_data && rmw_read);
  c_mem_mux: cover property (mem_active && mem_mode == MEM_MUX);
  c_open_float: cover property (port_six_pin_out != 8'h00 && port_six_pin_oe == 8'h00);

endmodule

// *** hw/high_port_pkg.sv ***
// Constants and types shared by the high-port I/O bank
package high_port_pkg;

  // ==========================================================
  // Widths
  localparam int          PORT_W               = 8;

  // ==========================================================
  // Register page and addresses
  localparam logic [7:0]  SFR_PAGE_F           = 8'h0f;
  localparam logic [7:0]  PORT_FIVE_DATA_ADDR  = 8'hd8;
  localparam logic [7:0]  PORT_SIX_DATA_ADDR   = 8'he8;
  localparam logic [7:0]  PORT_FOUR_DRIVE_ADDR = 8'h9c;
  localparam logic [7:0]  PORT_FIVE_DRIVE_ADDR = 8'h9d;
  localparam logic [7:0]  PORT_SIX_DRIVE_ADDR  = 8'h9e;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  DRIVE_RESET          = 8'h00;
  localparam logic [7:0]  LATCH_RESET          = 8'hff;
  localparam logic [7:0]  RDATA_RESET          = 8'h00;

  // ==========================================================
  // External memory address byte positions
  localparam int          ADDR_HI_LSB          = 8;
  localparam int          ADDR_LO_LSB          = 0;

  typedef enum logic {
    MEM_MUX    = 1'b0,
    MEM_NONMUX = 1'b1
  } mem_mode_t;

endpackage

// *** hw/port_pin_driver.sv ***
// Per-pin output value and enable for one 8-bit port
`timescale 1ns/100ps
module port_pin_driver #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] drive_select,
  input  wire logic             mem_take,
  input  wire logic [WIDTH-1:0] mem_value,
  output logic      [WIDTH-1:0] pin_out_next,
  output logic      [WIDTH-1:0] pin_oe_next
);

  // ==========================================================
  // Drive per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic value;
      // The memory interface replaces only the value; the drive mode still applies
      assign value           = mem_take ? mem_value[i] : latch[i];
      assign pin_out_next[i] = value;
      // Low always drives; high drives only in push-pull, else floats
      assign pin_oe_next[i]  = ~value | drive_select[i];
    end
  endgenerate

endmodule

// *** hw/high_port_gpio_bank_dummy_guard.sv ***
// (intentionally left minimal: no extra module)

// *** dv/port_load_model.sv ***
// External circuitry on one port: pull-ups plus an optional external driver
`timescale 1ns/100ps
module port_load_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  // ==========================================
  // Wire resolution
  // A released pin rises through its pull-up unless the outside pulls it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule

// *** dv/test_high_port_gpio_bank.sv ***
// Register-level tests of the high-port I/O bank
`timescale 1ns/100ps
module test_high_port_gpio_bank;
  import high_port_pkg::*;
  logic             clock = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       sfr_addr = 8'h00;
  logic [7:0]       page = 8'h0f;
  logic             sfr_wr = 1'b0;
  logic             sfr_rd = 1'b0;
  logic             rmw_read = 1'b0;
  logic [7:0]       sfr_wdata = 8'h00;
  logic [7:0]       sfr_rdata;
  logic             sfr_hit;
  logic             mem_active = 1'b0;
  mem_mode_t        mem_mode = MEM_MUX;
  logic [15:0]      mem_addr = 16'h0000;
  logic [7:0]       five_in, five_out, five_oe, six_in, six_out, six_oe, four_drive;
  logic [7:0]       ext_en = 8'h00;
  logic [7:0]       ext_val = 8'h00;
  int               err_total = 0;
  int               samples_checked = 0;

  always #12.5 clock = ~clock;

  high_port_gpio_bank u_high_port_gpio_bank (
    .clock(clock), .reset(reset), .sfr_addr(sfr_addr), .register_page_select(page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .rmw_read(rmw_read), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .mem_active(mem_active),
    .mem_mode(mem_mode), .mem_addr(mem_addr), .port_five_pin_in(five_in),
    .port_five_pin_out(five_out), .port_five_pin_oe(five_oe), .port_six_pin_in(six_in),
    .port_six_pin_out(six_out), .port_six_pin_oe(six_oe), .port_four_drive_select(four_drive));
  port_load_model u_port_load_model_five (
    .pin_out(five_out), .pin_oe(five_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(five_in));
  port_load_model u_port_load_model_six (
    .pin_out(six_out), .pin_oe(six_oe), .ext_en(8'h00), .ext_val(8'h00),
    .pin_level(six_in));

  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // A strobe stays up until the next call changes it, so no strobe is
  // assigned twice in one time step; repeated accesses are harmless here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_rd = 1'b0;
    rmw_read = 1'b0;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic rmw, input logic [7:0] exp,
                    input logic hit);
    sfr_wr = 1'b0;
    sfr_addr = a;
    rmw_read = rmw;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1;
    chk(sfr_rdata, exp);
    chk({7'd0, sfr_hit}, {7'd0, hit});
  endtask

  // ==========================================
  // Watchdog
  initial begin
    #(2000 * 25);
    err_total++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    #1 reset = 1'b0;
    chk(five_oe, 8'h00);
    chk(six_oe, 8'h00);
    rd(8'h9c, 1'b0, 8'h00, 1'b1);
    rd(8'h9d, 1'b0, 8'h00, 1'b1);
    rd(8'h9e, 1'b0, 8'h00, 1'b1);
    wr(8'h9c, 8'h96);
    chk(four_drive, 8'h96);
    rd(8'h9c, 1'b0, 8'h96, 1'b1);
    wr(8'h9d, 8'h0f);
    wr(8'hd8, 8'h5a);
    chk(five_out, 8'h5a);
    chk(five_oe, 8'haf);
    rd(8'h9d, 1'b0, 8'h0f, 1'b1);
    ext_en = 8'hf0;
    rd(8'hd8, 1'b0, 8'h0a, 1'b1);
    rd(8'hd8, 1'b1, 8'h5a, 1'b1);
    ext_en = 8'h00;
    page = 8'h0e;
    wr(8'hd8, 8'h00);
    chk(five_out, 8'h5a);
    rd(8'hd8, 1'b0, 8'h00, 1'b0);
    page = 8'h0f;
    rd(8'h9f, 1'b0, 8'h00, 1'b0);
    wr(8'he8, 8'hc3);
    chk(six_out, 8'hc3);
    chk(six_oe, 8'h3c);
    wr(8'h9e, 8'hff);
    chk(six_oe, 8'hff);
    rd(8'he8, 1'b0, 8'hc3, 1'b1);
    rd(8'he8, 1'b1, 8'hc3, 1'b1);
    wr(8'h9d, 8'hff);
    wr(8'hd8, 8'h3c);
    chk(five_out, 8'h3c);
    chk(five_oe, 8'hff);
    mem_active = 1'b1;
    mem_mode = MEM_NONMUX;
    mem_addr = 16'h1234;
    @(posedge clock);
    #1 chk(five_out, 8'h12);
    chk(six_out, 8'h34);
    mem_mode = MEM_MUX;
    @(posedge clock);
    #1 chk(six_out, 8'h12);
    chk(five_out, 8'h3c);
    mem_active = 1'b0;
    @(posedge clock);
    #1 chk(six_out, 8'hc3);
    tally_and_finish();
  end
endmodule
